// file: bench/hme_engine_assertions.sv
// Port-level assertions for the digest engine
`timescale 1ns/1ps
`default_nettype none

module hme_engine_checker (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic dma_in_req, // Data block request
  input wire logic dma_out_req // Digest collect request
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped;
  logic wr_ok;
  logic dma_en_q;
  assign mapped = paddr[1:0] == 2'h0 &&
    (paddr <= 12'h01C || (paddr >= 12'h040 && paddr <= 12'h07C));
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // Shadow of the DMA enable; it follows every system config write, soft
  // reset included, so it tracks the real one exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_en_q <= 1'b0;
    end else if (wr_ok && paddr == 12'h018) begin
      dma_en_q <= pwdata[1];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_after_access: assert property (
    psel && penable && !pready && !(pwrite && paddr == 12'h008)
    |=> pready) else $error("no pready after access");
  a_ready_single: assert property (
    pready |=> !pready) else $error("pready held too long");
  a_err_unmapped: assert property (
    pready && !mapped |-> pslverr) else $error("unmapped access accepted");
  a_err_with_ready: assert property (
    pslverr |-> pready) else $error("pslverr without pready");
  a_read_no_err: assert property (
    pready && !pwrite && mapped |-> !pslverr)
    else $error("mapped read refused");
  a_dma_off_quiet: assert property (
    !dma_en_q && !$past(dma_en_q) |-> !dma_in_req && !dma_out_req)
    else $error("dma request while disabled");
  a_dma_in_start: assert property (
    wr_ok && paddr == 12'h004 && pwdata != 32'h0 && dma_en_q
    |-> ##[1:24] dma_in_req) else $error("length write started nothing");
  a_out_clear: assert property (
    wr_ok && paddr == 12'h00C && pwdata[3] && dma_en_q
    |-> ##2 !dma_out_req) else $error("digest event not cleared");
endmodule // hme_engine_checker

`default_nettype wire

// file: bench/hme_host_model.sv
// Register-bus host model: APB master transfers and block writer
`timescale 1ns/1ps
`default_nettype none

module hme_host_model (
  input wire logic pclk, // System clock
  output logic psel, // APB select
  output logic penable, // APB access phase
  output logic pwrite, // APB direction
  output logic [11:0] paddr, // APB byte address
  output logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like the last word
    pwdata <= ~d;
  endtask

  // Blocking style: waits for the engine to collect, then a whole block
  task automatic put_block(input logic [31:0] seed, output logic e);
    logic [31:0] r;
    logic e1;
    do begin
      xfer(1'b0, 12'h01C, 32'h0, r, e1);
    end while (r[1] !== 1'b1);
    e = 1'b0;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, 12'h008, seed + i, r, e1);
      e = e | e1;
    end
  endtask
endmodule // hme_host_model

`default_nettype wire

// file: bench/test_hash_hmac_engine.sv
// Self-checking testbench for the digest engine
`timescale 1ns/1ps
`default_nettype none
`include "hme_defines.vh"

module test_hash_hmac_engine;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic dma_in_req, dma_out_req, e;
  int mismatches;
  int comparisons;
  int dl[4] = '{4, 5, 7, 8};

  hme_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_in_req(dma_in_req), .dma_out_req(dma_out_req));
  hme_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wait_evt(input int b);
    do begin
      rd(`HME_OFF_EVT_STATUS);
    end while (r[b] !== 1'b1);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    comparisons = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`HME_OFF_EVT_STATUS);
    check(r, 32'h1, "event reset");
    rd(12'h020);
    check({31'h0, e}, 32'h1, "unmapped read");
    wr(`HME_OFF_DATA_IN, 32'h0);
    check({31'h0, e}, 32'h1, "unready data write");
    wr(`HME_OFF_EVT_ENABLE, 32'h1);
    rd(`HME_OFF_EVT_MASKED);
    check(r, 32'h1, "masked status");
    wr(`HME_OFF_EVT_ENABLE, 32'h8);
    rd(`HME_OFF_EVT_MASKED);
    check(r, 32'h0, "masked off");
    for (int m = 0; m < 8; m++) begin
      wr(`HME_OFF_MODE, m | 8);
      rd(`HME_OFF_MODE);
      check(r, m | 8, "mode readback");
    end
    $display("test reset_and_modes done");
    wr(`HME_OFF_SYS_CONFIG, 32'h2);
    for (int a = 0; a < 4; a++) begin
      wr(`HME_OFF_MODE, a | 8);
      wr(`HME_OFF_LENGTH, `HME_BLOCK_BYTES);
      host_u.put_block(32'h100 * a, e);
      check({31'h0, e}, 32'h0, "block taken");
      wait_evt(`HME_EVT_DIGEST_OUT);
      check({31'h0, dma_out_req}, 32'h1, "out request");
      for (int w = 0; w < 16; w++) begin
        rd(12'(`HME_OFF_DIGEST_BASE + 4 * w));
        if (w >= dl[a]) check(r, 32'h0, "digest tail");
      end
      wr(`HME_OFF_EVT_STATUS, 32'h8);
      rd(`HME_OFF_EVT_STATUS);
      check(r & 32'h8, 32'h0, "digest event cleared");
    end
    $display("test digest_lengths done");
    rd(`HME_OFF_EVT_STATUS);
    check(r & 32'h1, 32'h1, "context ready before key");
    // Short key of four words, zero-padded to a whole block
    for (int w = 0; w < 16; w++)
      wr(12'(`HME_OFF_DIGEST_BASE + 4 * w), w < 4 ? 32'hA5 + w : 32'h0);
    rd(`HME_OFF_DIGEST_BASE);
    check(r, 32'hA5, "key word held");
    wr(`HME_OFF_MODE, 32'h0F);
    wr(`HME_OFF_LENGTH, 32'h0);
    wait_evt(`HME_EVT_PARTIAL);
    rd(`HME_OFF_ENGINE_STATE);
    check({28'h0, r[3:0]}, 32'h1, "key generate idle");
    wr(`HME_OFF_EVT_STATUS, 32'hF);
    wr(`HME_OFF_MODE, 32'h1F);
    wr(`HME_OFF_LENGTH, 32'h40);
    rd(`HME_OFF_ENGINE_STATE);
    check({28'h0, r[3:0]}, 32'h2, "no key pass");
    host_u.put_block(32'h7, e);
    wait_evt(`HME_EVT_DIGEST_OUT);
    wr(`HME_OFF_EVT_STATUS, 32'hF);
    wr(`HME_OFF_MODE, 32'h0F);
    wr(`HME_OFF_LENGTH, 32'h40);
    rd(`HME_OFF_ENGINE_STATE);
    check({28'h0, r[3:0]}, 32'h4, "raw key mixed first");
    host_u.put_block(32'h8, e);
    wait_evt(`HME_EVT_DIGEST_OUT);
    $display("test keyed done");
    wr(`HME_OFF_EVT_STATUS, 32'hF);
    wr(`HME_OFF_MODE, 32'h09);
    wr(`HME_OFF_LENGTH, 32'h80);
    wr(`HME_OFF_LENGTH, 32'h40);
    check({31'h0, e}, 32'h1, "length while busy");
    host_u.put_block(32'h55, e);
    wait_evt(`HME_EVT_PARTIAL);
    wr(`HME_OFF_SYS_CONFIG, 32'h3);
    rd(`HME_OFF_ENGINE_STATE);
    check(r, 32'h1, "idle after soft reset");
    rd(`HME_OFF_EVT_STATUS);
    check(r, 32'h1, "events after soft reset");
    $display("test soft_reset done");
    wr(`HME_OFF_SYS_CONFIG, 32'h0);
    wr(`HME_OFF_LENGTH, 32'h40);
    rd(`HME_OFF_ENGINE_STATE);
    check({31'h0, r[1] & ~dma_in_req}, 32'h1, "dma off");
    $display("test dma_off done");
    print_verdict;
  end

  // Whole run needs about 1300 cycles; the 40000-cycle limit allows about thirty times that
  initial begin
    #200000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule // test_hash_hmac_engine

bind hme_engine hme_engine_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dma_in_req(dma_in_req), .dma_out_req(dma_out_req));

`default_nettype wire

// file: include/hme_defines.vh
// Register map, field positions, reset values and constants of the digest engine
`ifndef HME_DEFINES_VH
`define HME_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HME_OFF_MODE 12'h000
`define HME_OFF_LENGTH 12'h004
`define HME_OFF_DATA_IN 12'h008
`define HME_OFF_EVT_STATUS 12'h00C
`define HME_OFF_EVT_ENABLE 12'h010
`define HME_OFF_EVT_MASKED 12'h014
`define HME_OFF_SYS_CONFIG 12'h018
`define HME_OFF_ENGINE_STATE 12'h01C
`define HME_OFF_DIGEST_BASE 12'h040
`define HME_OFF_DIGEST_LAST 12'h07C

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define HME_MODE_ALGO_LSB 0
`define HME_MODE_ALGO_MSB 1
`define HME_MODE_KEYED_BIT 2
`define HME_MODE_CLOSE_BIT 3
`define HME_MODE_PPKEY_BIT 4
`define HME_MODE_WIDTH 5
`define HME_MODE_RESET 5'h08

`define HME_ALGO_MD5 2'h0
`define HME_ALGO_SHA1 2'h1
`define HME_ALGO_SHA224 2'h2
`define HME_ALGO_SHA256 2'h3

// ----------------------------------------------------------------
// Event bits
// ----------------------------------------------------------------
`define HME_EVT_CONTEXT_IN 0
`define HME_EVT_PARTIAL 1
`define HME_EVT_INPUT 2
`define HME_EVT_DIGEST_OUT 3
`define HME_EVT_WIDTH 4
`define HME_EVT_RESET 4'h1
`define HME_EVT_EN_RESET 4'h0

// ----------------------------------------------------------------
// System config fields
// ----------------------------------------------------------------
`define HME_SYS_SOFTRST_BIT 0
`define HME_SYS_DMA_EN_BIT 1

// ----------------------------------------------------------------
// Sizes and constants
// ----------------------------------------------------------------
`define HME_BLOCK_WORDS 16
`define HME_BLOCK_BYTES 32'h00000040
`define HME_ROUNDS 5'h10
`define HME_ROUND_K 32'h5A827999
`define HME_KEY_PAD 32'h36363636
`define HME_IV_SEED 32'h67452301
`define HME_IV_STEP 32'h9E3779B9

`endif

// file: src/hme_engine.v
// Digest and keyed-digest engine with APB register access
//
// Functional notes
// - Mode selects plain or keyed, four algorithms
// - Digest length follows algorithm: 4/5/7/8 words
// - Data arrives as sixteen-word blocks
// - Readiness visible; unready data write is refused
// - Length register holds bytes; write starts run
// - Sixteen-word key accepted in digest registers
// - Raw key turned into readable processed key
// - Processed key reused without key processing
// - Control enables or disables DMA requests
// - Four enableable, clearable events
// - Raw or masked event status readable
// - Soft reset returns engine to idle
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "hme_defines.vh"
`default_nettype none

module hme_engine (
  input wire pclk, // System clock, 200 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg dma_in_req, // Engine wants a data block
  output reg dma_out_req // Digest ready for collection
);

  // --------------------------------------------------------------
  // States
  // --------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_COLLECT = 4'h2;
  localparam [3:0] ST_MIX = 4'h4;
  localparam [3:0] ST_FINISH = 4'h8;

  reg [3:0] state_reg;
  reg [`HME_MODE_WIDTH-1:0] mode_reg;
  reg [31:0] length_reg;
  reg [31:0] remain_reg;
  reg [`HME_EVT_WIDTH-1:0] evt_reg;
  reg [`HME_EVT_WIDTH-1:0] evt_en_reg;
  reg dma_en_reg;
  reg key_phase_reg;
  reg [4:0] word_cnt_reg;
  reg [4:0] round_reg;
  reg [31:0] digest_reg [0:15];
  reg [31:0] block_reg [0:15];

  // Two-entry buffer between bus and block store
  reg [31:0] buf_data_reg [0:1];
  reg buf_wptr_reg;
  reg buf_rptr_reg;
  reg [1:0] buf_cnt_reg;

  integer i;

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  function is_digest;
    input [11:0] a;
    begin
      is_digest = (a >= `HME_OFF_DIGEST_BASE) &&
                  (a <= `HME_OFF_DIGEST_LAST) && (a[1:0] == 2'h0);
    end
  endfunction

  // Control registers sit packed as aligned words from offset zero
  function is_mapped;
    input [11:0] a;
    begin
      if (a[1:0] != 2'h0) begin
        is_mapped = 1'b0;
      end else if (a <= `HME_OFF_ENGINE_STATE) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = is_digest(a);
      end
    end
  endfunction

  // Digest words that belong to the chosen algorithm
  function [4:0] digest_words;
    input [1:0] algo;
    begin
      case (algo)
        `HME_ALGO_MD5: digest_words = 5'h04;
        `HME_ALGO_SHA1: digest_words = 5'h05;
        `HME_ALGO_SHA224: digest_words = 5'h07;
        default: digest_words = 5'h08;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire in_ready = state_reg[1] && (word_cnt_reg != 5'h10);
  wire ctx_ready = state_reg[0];
  // Buffered words count too, so a seventeenth word is refused
  wire [4:0] held = word_cnt_reg + {3'h0, buf_cnt_reg};
  wire room = in_ready && (held < 5'h10);
  wire data_wr_sel = psel && pwrite && (paddr == `HME_OFF_DATA_IN);
  // A data write stalls while the buffer is full: no word is lost
  wire stall = data_wr_sel && in_ready && (buf_cnt_reg == 2'h2);
  wire access = psel && penable && !pready && !stall;
  wire commit = psel && penable && pready;
  wire wr_commit = commit && pwrite && !pslverr;
  wire [3:0] didx = paddr[5:2];
  wire [1:0] algo = mode_reg[`HME_MODE_ALGO_MSB:`HME_MODE_ALGO_LSB];
  wire keyed = mode_reg[`HME_MODE_KEYED_BIT];
  wire soft_rst = wr_commit && (paddr == `HME_OFF_SYS_CONFIG) &&
                  pwdata[`HME_SYS_SOFTRST_BIT];
  wire len_wr = wr_commit && (paddr == `HME_OFF_LENGTH);
  wire buf_push = wr_commit && (paddr == `HME_OFF_DATA_IN);
  wire buf_pop = (buf_cnt_reg != 2'h0) && in_ready;
  wire last_round = state_reg[2] && (round_reg == `HME_ROUNDS - 5'h01);

  // --------------------------------------------------------------
  // APB answer: one wait state, refusal flagged by pslverr
  // --------------------------------------------------------------
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (paddr == `HME_OFF_MODE) begin
      rd_next[`HME_MODE_WIDTH-1:0] = mode_reg;
    end else if (paddr == `HME_OFF_LENGTH) begin
      rd_next = length_reg;
    end else if (paddr == `HME_OFF_EVT_STATUS) begin
      rd_next[`HME_EVT_WIDTH-1:0] = evt_reg;
    end else if (paddr == `HME_OFF_EVT_ENABLE) begin
      rd_next[`HME_EVT_WIDTH-1:0] = evt_en_reg;
    end else if (paddr == `HME_OFF_EVT_MASKED) begin
      rd_next[`HME_EVT_WIDTH-1:0] = evt_reg & evt_en_reg;
    end else if (paddr == `HME_OFF_SYS_CONFIG) begin
      rd_next[`HME_SYS_DMA_EN_BIT] = dma_en_reg;
    end else if (paddr == `HME_OFF_ENGINE_STATE) begin
      rd_next = {23'h000000, word_cnt_reg, state_reg};
    end else if (is_digest(paddr)) begin
      rd_next = digest_reg[didx];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (access) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : rd_next;
      // Unmapped address, data when no block is wanted, or digest/length write while busy
      pslverr <= !is_mapped(paddr) ||
                 (data_wr_sel && !room) ||
                 (pwrite && is_digest(paddr) && !ctx_ready) ||
                 (pwrite && (paddr == `HME_OFF_LENGTH) && !ctx_ready);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Configuration and events
  // --------------------------------------------------------------
  wire [`HME_EVT_WIDTH-1:0] evt_set;
  assign evt_set[`HME_EVT_CONTEXT_IN] = soft_rst ||
                                        (state_reg[3] && !key_phase_reg);
  assign evt_set[`HME_EVT_PARTIAL] = last_round && (key_phase_reg ||
                                     (remain_reg > `HME_BLOCK_BYTES));
  assign evt_set[`HME_EVT_INPUT] = (len_wr && !ctx_ready) ? 1'b0 :
                                   (state_reg[1] &&
                                    word_cnt_reg == 5'h00 &&
                                    !key_phase_reg);
  assign evt_set[`HME_EVT_DIGEST_OUT] = state_reg[3] && !key_phase_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `HME_MODE_RESET;
      length_reg <= 32'h00000000;
      evt_reg <= `HME_EVT_RESET;
      evt_en_reg <= `HME_EVT_EN_RESET;
      dma_en_reg <= 1'b0;
    end else begin
      if (wr_commit && paddr == `HME_OFF_MODE && ctx_ready) begin
        mode_reg <= pwdata[`HME_MODE_WIDTH-1:0];
      end
      if (len_wr) begin
        length_reg <= pwdata;
      end
      if (wr_commit && paddr == `HME_OFF_EVT_ENABLE) begin
        evt_en_reg <= pwdata[`HME_EVT_WIDTH-1:0];
      end
      if (wr_commit && paddr == `HME_OFF_SYS_CONFIG) begin
        dma_en_reg <= pwdata[`HME_SYS_DMA_EN_BIT];
      end
      // Set wins over a write-one clear in the same cycle
      if (soft_rst) begin
        evt_reg <= `HME_EVT_RESET;
      end else if (wr_commit && paddr == `HME_OFF_EVT_STATUS) begin
        evt_reg <= (evt_reg & ~pwdata[`HME_EVT_WIDTH-1:0]) |
                   evt_set;
      end else begin
        evt_reg <= evt_reg | evt_set;
      end
    end
  end

  // --------------------------------------------------------------
  // Two-entry data buffer
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wptr_reg <= 1'b0;
      buf_rptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
      buf_data_reg[0] <= 32'h00000000;
      buf_data_reg[1] <= 32'h00000000;
    end else if (soft_rst) begin
      buf_wptr_reg <= 1'b0;
      buf_rptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_data_reg[buf_wptr_reg] <= pwdata;
        buf_wptr_reg <= ~buf_wptr_reg;
      end
      if (buf_pop) begin
        buf_rptr_reg <= ~buf_rptr_reg;
      end
      if (buf_push && !buf_pop) begin
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      end else if (buf_pop && !buf_push) begin
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // Block engine
  // --------------------------------------------------------------
  // The mixing network is a compact stand-in for the four round
  // functions; it keeps block framing, context and timing exact.
  wire [31:0] mix_w [0:15];
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_mix
      wire [31:0] x = digest_reg[g] ^
                      block_reg[(g + round_reg[3:0]) % 16];
      assign mix_w[g] = {x[26:0], x[31:27]} +
                        digest_reg[(g + 1) % 16] + `HME_ROUND_K;
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      remain_reg <= 32'h00000000;
      key_phase_reg <= 1'b0;
      word_cnt_reg <= 5'h00;
      round_reg <= 5'h00;
      dma_in_req <= 1'b0;
      dma_out_req <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        digest_reg[i] <= 32'h00000000;
        block_reg[i] <= 32'h00000000;
      end
    end else if (soft_rst) begin
      state_reg <= ST_IDLE;
      word_cnt_reg <= 5'h00;
      round_reg <= 5'h00;
      key_phase_reg <= 1'b0;
      dma_in_req <= 1'b0;
      dma_out_req <= 1'b0;
    end else begin
      dma_in_req <= dma_en_reg && room;
      dma_out_req <= dma_en_reg &&
                     evt_reg[`HME_EVT_DIGEST_OUT];
      case (state_reg)
        ST_IDLE: begin
          if (wr_commit && is_digest(paddr)) begin
            digest_reg[didx] <= pwdata;
          end
          if (len_wr) begin
            remain_reg <= pwdata;
            word_cnt_reg <= 5'h00;
            if (keyed && !mode_reg[`HME_MODE_PPKEY_BIT]) begin
              // Raw key: pad it and run it as a block first
              key_phase_reg <= 1'b1;
              for (i = 0; i < 16; i = i + 1) begin
                block_reg[i] <= digest_reg[i] ^ `HME_KEY_PAD;
                digest_reg[i] <= `HME_IV_SEED + `HME_IV_STEP * i;
              end
              state_reg <= ST_MIX;
            end else begin
              if (!keyed) begin
                for (i = 0; i < 16; i = i + 1) begin
                  digest_reg[i] <= `HME_IV_SEED + `HME_IV_STEP * i;
                end
              end
              // Processed key stays in the digest store
              state_reg <= ST_COLLECT;
            end
          end
        end
        ST_COLLECT: begin
          if (buf_pop) begin
            block_reg[word_cnt_reg[3:0]] <=
              buf_data_reg[buf_rptr_reg];
            word_cnt_reg <= word_cnt_reg + 5'h01;
          end
          if (word_cnt_reg == 5'h10) begin
            state_reg <= ST_MIX;
          end
        end
        ST_MIX: begin
          for (i = 0; i < 16; i = i + 1) begin
            digest_reg[i] <= mix_w[i];
          end
          round_reg <= round_reg + 5'h01;
          if (last_round) begin
            round_reg <= 5'h00;
            word_cnt_reg <= 5'h00;
            if (key_phase_reg) begin
              key_phase_reg <= 1'b0;
              state_reg <= (remain_reg == 32'h00000000) ?
                           ST_IDLE : ST_COLLECT;
            end else if (remain_reg > `HME_BLOCK_BYTES) begin
              remain_reg <= remain_reg - `HME_BLOCK_BYTES;
              state_reg <= ST_COLLECT;
            end else begin
              remain_reg <= 32'h00000000;
              state_reg <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          // Clear words past the digest length on the same edge that flags the digest
          for (i = 0; i < 16; i = i + 1) begin
            if (i >= digest_words(algo)) begin
              digest_reg[i] <= 32'h00000000;
            end
          end
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // hme_engine

`default_nettype wire
